// ### tdm_ingress_defines.svh
// timing and layout constants for the ingress signaling outputs
`ifndef TDM_INGRESS_DEFINES_SVH
`define TDM_INGRESS_DEFINES_SVH
// number of serial outputs per kind
`define CAS_OUTPUTS 21
`define GROUP_SIZE 7
`define GROUPS 3
// bit positions in one 125 us frame at 8.192 Mbit/s
`define BITS_PER_FRAME 1024
`define BIT_CNT_W 10
// frames per multiframe when the frame pulse marks single frames
`define MFRAME_LEN 6'd48
// slot byte layout on a per-link signaling output
`define CAS_NIB_HI 7
`define CAS_FRAMER_POS 3
`define CAS_ALARM_POS 2
// reset values
`define EDGE_SEL_RST 1'b0
`define BIT_CNT_RST 10'h000
`endif

// ### tdm_ingress_pkg.sv
// types shared by the ingress signaling output block
package tdm_ingress_pkg;
  // link type carried by one group of seven outputs
  typedef enum logic {
    link_t1,
    link_e1
  } link_mode_t;
  // update edge of the port bit clock
  typedef enum logic {
    upd_rising,
    upd_falling
  } upd_edge_t;
endpackage

// ### tdm_ingress_signaling_outputs.sv
// ingress signaling, common channel and slot-zero serial output block
//
// Behaviour
// - each signaling output carries one link's signaling nibble
// - signaling output also carries framer and alarm status
// - outputs change on every second selected port clock edge
// - configuration bit picks rising or falling update edge
// - t1 or e1 chosen per group of links
// - three independent groups of seven outputs
// - e1 groups leave their seventh output unused
// - t1: first common-channel output carries 84 channels
// - e1: three common-channel outputs carry slots 15,16,31
`timescale 1ns/1ns
`include "tdm_ingress_defines.svh"
module tdm_ingress_signaling_outputs
  import tdm_ingress_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // backplane timing pins
  input wire logic port_bit_clock_in,
  input wire logic port_frame_pulse_clock_in,
  input wire logic port_frame_pulse_n_in,
  // configuration from local logic
  input wire logic ingress_update_edge_sel_in,
  input wire logic multiframe_pulse_sel_in,
  input wire logic [2:0] group_e1_in,
  // slot contents from the framers
  input wire logic [83:0] cas_nibble_in,
  input wire logic [20:0] framer_status_in,
  input wire logic [20:0] alarm_status_in,
  input wire logic [23:0] ccs_byte_in,
  input wire logic [7:0] e1_slot0_byte_in,
  // position in the frame for the framers
  output logic [6:0] slot_index_out,
  output logic [5:0] mframe_index_out,
  // serial outputs
  output logic [20:0] cas_ingress_out,
  output logic [2:0] ccs_ingress_out,
  output logic e1_slot0_ingress_out
);

  // one slot byte of a signaling output
  function automatic logic [7:0] cas_byte(input logic [3:0] nib,
                                          input logic fr,
                                          input logic al);
    cas_byte = {nib, fr, al, 2'b00};
  endfunction

  // bit of a byte for a position, msb first
  function automatic logic bit_of(input logic [7:0] b,
                                  input logic [2:0] pos);
    bit_of = b[3'h7 - pos];
  endfunction

  // synchronisers for the backplane pins
  logic bclk_s1_q, bclk_s2_q, bclk_s3_q;
  logic fpc_s1_q, fpc_s2_q, fpc_s3_q;
  logic fp_s1_q, fp_s2_q;
  // configuration and sequencing state
  upd_edge_t edge_sel_q;
  logic phase_q;
  logic skip_seen_q; // a selected edge passed over since the last update
  logic fp_seen_q;
  logic [`BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
  logic [5:0] mframe_q, mframe_d;
  // held slot bytes and output flops
  logic [167:0] cas_hold_q, cas_live;
  logic [23:0] ccs_hold_q, ccs_cur;
  logic [7:0] ts0_hold_q, ts0_cur;
  logic [167:0] cas_cur;
  logic [20:0] cas_q, cas_d;
  logic [2:0] ccs_q, ccs_d;
  logic ts0_q;

  // pin synchronisers, first stage read only by the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {bclk_s1_q, bclk_s2_q, bclk_s3_q} <= 3'h0;
      {fpc_s1_q, fpc_s2_q, fpc_s3_q} <= 3'h0;
      {fp_s1_q, fp_s2_q} <= 2'h3;
    end else begin
      {bclk_s1_q, bclk_s2_q, bclk_s3_q} <=
        {port_bit_clock_in, bclk_s1_q, bclk_s2_q};
      {fpc_s1_q, fpc_s2_q, fpc_s3_q} <=
        {port_frame_pulse_clock_in, fpc_s1_q, fpc_s2_q};
      {fp_s1_q, fp_s2_q} <= {port_frame_pulse_n_in, fp_s1_q};
    end
  end

  // edge detection on the synchronised clocks
  wire bclk_rise = bclk_s2_q & ~bclk_s3_q;
  wire bclk_fall = ~bclk_s2_q & bclk_s3_q;
  wire fpc_fall = ~fpc_s2_q & fpc_s3_q;
  // selected port clock edge
  wire sel_edge = (edge_sel_q == upd_falling) ? bclk_fall : bclk_rise;
  // pulse clock fall restarts the two-edge phase
  wire upd = sel_edge & ~phase_q & ~fpc_fall;
  // frame pulse caught at this pulse clock fall
  wire fp_now = fpc_fall & ~fp_s2_q;
  wire frame_start = fp_seen_q | fp_now;
  wire slot_load = (bit_cnt_d[2:0] == 3'h0);

  // config bit register, rising edge after reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      edge_sel_q <= upd_rising;
    end else begin
      edge_sel_q <= upd_edge_t'(ingress_update_edge_sel_in);
    end
  end

  // update phase: every second selected edge; after a pulse clock fall
  // the next selected edge updates, so a coincident falling edge that
  // is blocked still leaves two updates per pulse clock period
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= 1'b0;
    end else if (fpc_fall) begin
      phase_q <= 1'b0;
    end else if (sel_edge) begin
      phase_q <= ~phase_q;
    end
  end

  // check helper: set by a selected edge that did not update
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      skip_seen_q <= 1'b1;
    end else if (upd) begin
      skip_seen_q <= 1'b0;
    end else if (sel_edge) begin
      skip_seen_q <= 1'b1;
    end
  end

  // pending frame start; a new pulse beats the clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fp_seen_q <= 1'b0;
    end else if (fp_now) begin
      fp_seen_q <= ~upd;
    end else if (upd) begin
      fp_seen_q <= 1'b0;
    end
  end

  // next bit position and multiframe count
  always_comb begin
    bit_cnt_d = bit_cnt_q + `BIT_CNT_W'(1);
    mframe_d = mframe_q;
    if (frame_start) begin
      bit_cnt_d = `BIT_CNT_RST;
      if (multiframe_pulse_sel_in) begin
        mframe_d = 6'h00;
      end else if (mframe_q == `MFRAME_LEN - 6'd1) begin
        mframe_d = 6'h00;
      end else begin
        mframe_d = mframe_q + 6'h01;
      end
    end else if (bit_cnt_q == `BIT_CNT_W'(`BITS_PER_FRAME - 1)) begin
      mframe_d = (mframe_q == `MFRAME_LEN - 6'd1) ? 6'h00
                 : mframe_q + 6'h01;
    end
  end

  // bit position counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt_q <= `BIT_CNT_RST;
      mframe_q <= 6'h00;
    end else if (upd) begin
      bit_cnt_q <= bit_cnt_d;
      mframe_q <= mframe_d;
    end
  end

  // slot bytes: live at slot start, held otherwise
  genvar gi;
  generate
    for (gi = 0; gi < `CAS_OUTPUTS; gi++) begin : g_cas
      // group of seven this output belongs to
      localparam int GRP = gi / `GROUP_SIZE;
      localparam bit LAST = ((gi % `GROUP_SIZE) == `GROUP_SIZE - 1);
      assign cas_live[gi*8 +: 8] = cas_byte(cas_nibble_in[gi*4 +: 4],
                                            framer_status_in[gi],
                                            alarm_status_in[gi]);
      assign cas_d[gi] = (LAST && group_e1_in[GRP]) ? 1'b0
                         : bit_of(cas_cur[gi*8 +: 8], bit_cnt_d[2:0]);
    end
    for (gi = 0; gi < `GROUPS; gi++) begin : g_ccs
      // t1 uses only the first, e1 uses all three
      wire ccs_on = (gi == 0) ? 1'b1 : group_e1_in[gi];
      assign ccs_d[gi] = ccs_on & bit_of(ccs_cur[gi*8 +: 8], bit_cnt_d[2:0]);
    end
  endgenerate
  assign cas_cur = slot_load ? cas_live : cas_hold_q;
  assign ccs_cur = slot_load ? ccs_byte_in : ccs_hold_q;
  assign ts0_cur = slot_load ? e1_slot0_byte_in : ts0_hold_q;

  // slot-zero output only in e1 and in slot zero
  wire ts0_d = group_e1_in[0] & (bit_cnt_d[`BIT_CNT_W-1:3] == 7'h00)
               & bit_of(ts0_cur, bit_cnt_d[2:0]);

  // output and hold registers, change only on update
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cas_hold_q <= '0;
      ccs_hold_q <= 24'h000000;
      ts0_hold_q <= 8'h00;
      cas_q <= 21'h000000;
      ccs_q <= 3'h0;
      ts0_q <= 1'b0;
    end else if (upd) begin
      cas_hold_q <= cas_cur;
      ccs_hold_q <= ccs_cur;
      ts0_hold_q <= ts0_cur;
      cas_q <= cas_d;
      ccs_q <= ccs_d;
      ts0_q <= ts0_d;
    end
  end

  // output wiring
  assign cas_ingress_out = cas_q;
  assign ccs_ingress_out = ccs_q;
  assign e1_slot0_ingress_out = ts0_q;
  assign slot_index_out = bit_cnt_q[`BIT_CNT_W-1:3];
  assign mframe_index_out = mframe_q;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  outputs_change_upd_a: assert property (
    !$past(upd) |-> $stable(cas_q) && $stable(ccs_q) && $stable(ts0_q))
    else $error("outputs changed without an update");
  upd_on_edge_a: assert property (
    upd |-> (edge_sel_q == upd_rising ? bclk_rise : bclk_fall))
    else $error("update not on the selected port clock edge");
  no_double_upd_a: assert property (
    upd |-> skip_seen_q)
    else $error("two updates on consecutive selected edges");
  e1_unused_low_a: assert property (
    group_e1_in[1] && $past(group_e1_in[1]) && $past(upd) |->
    !cas_ingress_out[13])
    else $error("unused e1 output not low");
  ccs_t1_off_a: assert property (
    !group_e1_in[2] && $past(!group_e1_in[2]) && $past(upd) |->
    !ccs_ingress_out[2])
    else $error("t1 group drives extra common-channel output");
  ts0_slot_a: assert property (
    $past(upd) && slot_index_out != 7'h00 |-> !e1_slot0_ingress_out)
    else $error("slot-zero output active outside slot zero");
  frame_start_a: assert property (
    upd && frame_start |=> bit_cnt_q == `BIT_CNT_RST)
    else $error("frame pulse did not restart the frame");
  cas_nibble_a: assert property (
    upd && bit_cnt_d[2:0] == 3'h0 && !group_e1_in[0] |=>
    cas_ingress_out[0] == $past(cas_nibble_in[3]))
    else $error("signaling bit not taken from the nibble");
  cas_status_a: assert property (
    upd && bit_cnt_d[2:0] == 3'h4 |=>
    cas_ingress_out[0] == $past(cas_hold_q[`CAS_FRAMER_POS]))
    else $error("framer status bit out of place");
  mframe_a: assert property (
    upd && frame_start && multiframe_pulse_sel_in |=> mframe_q == 6'h00)
    else $error("multiframe count not restarted");
  edge_reset_a: assert property (
    $rose(rst_n_in) |-> edge_sel_q == upd_rising)
    else $error("edge select not rising after reset");

  frame_cov: cover property (upd && frame_start);
  falling_cov: cover property (upd && edge_sel_q == upd_falling);
  e1_cov: cover property ($past(upd) && group_e1_in[0] &&
                          e1_slot0_ingress_out);
  mframe_cov: cover property (upd && mframe_q == `MFRAME_LEN - 6'd1);

endmodule

// ### hmvip_switch_model.sv
// backplane switch model: port clock, pulse clock and frame pulse
`timescale 1ns/1ns
module hmvip_switch_model (
  // backplane timing pins
  output logic port_bit_clock_out,
  output logic port_frame_pulse_clock_out,
  output logic port_frame_pulse_n_out
);
  logic bclk; // port clock, 800 ns period
  logic fpc; // pulse clock, four port periods
  int rises; // pulse clock rises so far
  assign port_bit_clock_out = bclk;
  assign port_frame_pulse_clock_out = fpc;
  // port clock runs free, as the backplane clock does
  initial begin
    bclk = 1'b1;
    forever #400 bclk = ~bclk;
  end
  // pulse clock falls together with a port clock fall
  initial begin
    fpc = 1'b1;
    #400 fpc = 1'b0;
    forever #1600 fpc = ~fpc;
  end
  // low across one fall every 512 pulse periods, one frame apart
  initial begin
    rises = 0;
    port_frame_pulse_n_out = 1'b1;
  end
  always @(posedge fpc) begin
    port_frame_pulse_n_out <= (rises % 512) != 36;
    rises <= rises + 1;
  end
endmodule

// ### test_tdm_ingress_signaling_outputs.sv
// testbench for the ingress signaling output block
`timescale 1ns/1ns
module test_tdm_ingress_signaling_outputs;
  import tdm_ingress_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  wire bclk, fpc, fpn; // backplane pins from the switch model
  logic edge_sel = 1'b0;
  logic mfp = 1'b0; // multiframe pulse select
  logic [2:0] grp = 3'h0; // e1 flag per group
  logic [83:0] nib = 84'hF0E1D2C3B4A5968778695;
  logic [20:0] fr = 21'h15A5C3;
  logic [20:0] al = 21'h0C3A5F;
  logic [23:0] ccs = 24'hC35A96;
  logic [7:0] s0 = 8'hA7;
  logic [6:0] slot;
  logic [5:0] mfr, m0;
  logic [20:0] cas_o;
  logic [2:0] ccs_o;
  logic s0_o;
  int errors = 0, samples_checked = 0, cycles = 0;
  time t_rise, t_fall, t_fp;
  always #50 clk_in = ~clk_in;
  hmvip_switch_model u_hmvip_switch_model (.port_bit_clock_out(bclk),
    .port_frame_pulse_clock_out(fpc), .port_frame_pulse_n_out(fpn));
  tdm_ingress_signaling_outputs u_tdm_ingress_signaling_outputs (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .port_bit_clock_in(bclk),
    .port_frame_pulse_clock_in(fpc), .port_frame_pulse_n_in(fpn),
    .ingress_update_edge_sel_in(edge_sel), .multiframe_pulse_sel_in(mfp),
    .group_e1_in(grp), .cas_nibble_in(nib), .framer_status_in(fr),
    .alarm_status_in(al), .ccs_byte_in(ccs), .e1_slot0_byte_in(s0),
    .slot_index_out(slot), .mframe_index_out(mfr),
    .cas_ingress_out(cas_o), .ccs_ingress_out(ccs_o),
    .e1_slot0_ingress_out(s0_o));
  // edge times of the backplane pins
  always @(posedge bclk) t_rise = $time;
  always @(negedge bclk) t_fall = $time;
  always @(negedge fpc) if (!fpn) t_fp = $time;
  // one comparison, counted
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // wait for the slot to start afresh
  task automatic wait_slot(logic [6:0] s);
    @(negedge clk_in);
    while (slot === s) @(negedge clk_in);
    while (slot !== s) @(negedge clk_in);
  endtask
  // capture one slot on every output, mid-bit, and judge it
  task automatic check_slot(logic [6:0] s);
    logic [24:0] va[8], vb[8];
    logic [7:0] got, exp;
    int j, k;
    wait_slot(s);
    for (k = 0; k < 8; k++) begin
      repeat (3) @(negedge clk_in);
      va[k] = {cas_o, ccs_o, s0_o};
      repeat (10) @(negedge clk_in);
      vb[k] = {cas_o, ccs_o, s0_o};
      repeat (3) @(negedge clk_in);
      chk("bit hold", {7'h00, va[k]}, {7'h00, vb[k]});
    end
    for (j = 0; j < 25; j++) begin
      for (k = 0; k < 8; k++) got[7 - k] = va[k][j];
      if (j >= 4) begin
        exp = {nib[4*(j-4) +: 4], fr[j-4], al[j-4], 2'b00};
        if (grp[(j - 4) / 7] && (j - 4) % 7 == 6) exp = 8'h00;
        chk("signaling byte", exp, got);
      end else if (j >= 1) begin
        exp = (j == 1 || grp[j - 1]) ? ccs[8*(j-1) +: 8] : 8'h00;
        chk("common channel byte", exp, got);
      end else begin
        exp = (grp[0] && s == 7'h00) ? s0 : 8'h00;
        chk("slot zero byte", exp, got);
      end
    end
  endtask
  // frame pulse restarts the slot count within one bit; with the
  // multiframe select set the first pulse also restarts the frame count
  task automatic frame_start();
    mfp = 1'b1;
    check_slot(7'h00);
    chk("pulse to slot zero", 1, ($time - t_fp) < 14500);
    chk("multiframe restart", 0, mfr);
    m0 = mfr;
    mfp = 1'b0;
  endtask
  // mixed groups, next frame, slot zero and a later slot
  task automatic mixed_groups();
    grp = 3'h5;
    check_slot(7'h00);
    chk("frame count", (m0 + 6'h01) % 48, mfr);
    grp = 3'h3;
    check_slot(7'h02);
  endtask
  // all t1 groups
  task automatic all_t1();
    grp = 3'h0;
    check_slot(7'h05);
  endtask
  // outputs follow the selected port clock edge
  task automatic update_edge(logic sel);
    time d;
    edge_sel = sel;
    repeat (3) @(slot);
    d = $time - (sel ? t_fall : t_rise);
    chk("update after edge", 1, d < 400);
    @(negedge clk_in);
  endtask
  // closing report
  task automatic summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      summarize();
    end
  end
  // main sequence
  initial begin
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    frame_start();
    mixed_groups();
    all_t1();
    update_edge(1'b0);
    update_edge(1'b1);
    check_slot(slot + 7'h03);
    summarize();
  end
endmodule
